//--- logic/rsi_decode.sv
`timescale 1ns/100ps
module rsi_decode
  import rsi_pkg::*;
(
  input  wire rsi_src_t  i_src,        // reset sources
  input  wire rsi_mode_t i_mode,       // current power mode
  output rsi_kind_t      o_kind        // decoded reset kind
);
  // power-on outranks all; undervoltage detector is off in idle/sleep
  always_comb begin
    o_kind = RSI_RK_NONE;
    if (i_src.power_on) begin
      o_kind = RSI_RK_POR;
    end else if (i_src.undervoltage_reset &&
                 (i_mode == RSI_MODE_FAST || i_mode == RSI_MODE_SLOW)) begin
      o_kind = RSI_RK_UVR;
    end else if (i_src.wdt_timeout) begin
      if (i_mode == RSI_MODE_IDLE || i_mode == RSI_MODE_SLEEP) begin
        o_kind = RSI_RK_WDT_LP;
      end else begin
        o_kind = RSI_RK_WDT_RUN;
      end
    end
  end
endmodule

//--- logic/rsi_pkg.sv
package rsi_pkg;

  localparam int RSI_DW = 8;

  // core status register bit positions
  localparam int RSI_ST_PDF_BIT = 4;
  localparam int RSI_ST_TO_BIT  = 5;

  // reset-cause flags register bit positions
  localparam int RSI_RCF_SWR_BIT = 0;
  localparam int RSI_RCF_UVR_BIT = 2;

  localparam logic [7:0] RSI_PORT_DATA_RST = 8'hff;
  localparam logic [7:0] RSI_PORT_DIR_RST  = 8'hff;
  localparam logic [7:0] RSI_PORT_PU_RST   = 8'h00;
  localparam logic [7:0] RSI_PORT_WU_RST   = 8'h00;
  localparam logic [7:0] RSI_ZERO8         = 8'h00;
  localparam logic [7:0] RSI_STATUS_RST    = 8'h00;
  localparam logic [7:0] RSI_RCF_RST       = 8'h00;
  localparam logic [7:0] RSI_RCF_MASK      = 8'h05;
  localparam logic [12:0] RSI_PC_RST       = 13'h0000;
  localparam int RSI_STACK_DEPTH           = 8;
  localparam logic [2:0] RSI_SP_TOP        = 3'h0;
  localparam logic [2:0] RSI_ACTION_CYCLES = 3'h1;

  // power modes
  typedef enum logic [3:0] {
    RSI_MODE_FAST  = 4'h1,
    RSI_MODE_SLOW  = 4'h2,
    RSI_MODE_IDLE  = 4'h4,
    RSI_MODE_SLEEP = 4'h8
  } rsi_mode_t;

  // decoded reset kind
  typedef enum logic [4:0] {
    RSI_RK_NONE    = 5'h01,
    RSI_RK_POR     = 5'h02,
    RSI_RK_UVR     = 5'h04,
    RSI_RK_WDT_RUN = 5'h08,
    RSI_RK_WDT_LP  = 5'h10
  } rsi_kind_t;

  typedef struct packed {
    logic power_on;
    logic undervoltage_reset;
    logic wdt_timeout;
  } rsi_src_t;

  typedef struct packed {
    logic [7:0] port_data;
    logic [7:0] port_dir;
    logic [7:0] port_pullup;
    logic [7:0] port_wakeup;
  } rsi_port_t;

  typedef struct packed {
    logic watchdog_timeout_flag;
    logic power_down_flag;
  } rsi_flags_t;

endpackage

//--- logic/rsi_reset_state_init.sv
`timescale 1ns/100ps
module rsi_reset_state_init
  import rsi_pkg::*;
(
  input  wire logic       i_ref_clk,         // system clock
  input  wire logic       i_rst,             // async reset, active high
  input  wire logic       i_power_on,        // power-on reset event (pin side)
  input  wire logic       i_undervoltage_reset, // valid undervoltage reset event
  input  wire logic       i_wdt_timeout,     // watchdog time-out event
  input  wire rsi_mode_t  i_mode,            // current power mode
  input  wire logic       i_halt,            // halt entry: sets power-down flag
  input  wire logic       i_clr_wdt,         // clear-watchdog instruction
  input  wire logic       i_wdt_sw_reset,    // watchdog-control software reset
  input  wire logic       i_rcf_clr_uvr,     // software clears undervoltage cause
  input  wire logic       i_rcf_clr_swr,     // software clears software-reset cause
  input  wire logic [7:0] i_working_d,       // core working register write value
  input  wire logic       i_working_we,      // core working register write
  input  wire logic [7:0] i_tbl_low_d,       // table pointer low write value
  input  wire logic       i_tbl_low_we,      // table pointer low write
  input  wire logic [7:0] i_tbl_high_d,      // table latch high write value
  input  wire logic       i_tbl_high_we,     // table latch high write
  output logic [7:0]      o_status,          // core status register
  output logic [7:0]      o_reset_cause_flags, // reset-cause flags register
  output logic [12:0]     o_pc,              // program counter
  output logic [2:0]      o_sp,              // stack pointer
  output logic            o_int_disable,     // force all interrupt enables off
  output logic            o_wdt_clear,       // clear watchdog/time-base counters
  output logic            o_wdt_run,         // watchdog counting
  output logic            o_timers_off,      // force timer modules off
  output rsi_port_t       o_port_init,       // port register load values
  output logic            o_port_load,       // load ports with o_port_init
  output logic            o_core_reset,      // core held in reset this cycle
  output logic [7:0]      o_working_register, // working register
  output logic [7:0]      o_table_pointer_low, // table pointer low
  output logic [7:0]      o_table_latch_high   // table latch high
);

  // pin-side events cross into the clock domain first
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  rsi_src_t   src;
  rsi_kind_t  kind;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {i_power_on, i_undervoltage_reset, i_wdt_timeout};
      sync2_q <= sync1_q;
    end
  end

  assign src = rsi_src_t'(sync2_q);

  rsi_decode u_decode (
    .i_src  (src),
    .i_mode (i_mode),
    .o_kind (kind)
  );

  // power-on reset flags, the status register and the core state
  logic       to_q;
  logic       pdf_q;
  logic [7:0] status_d;

  // time-out and power-down flags: decided from the same-cycle kind; the async reset
  // itself is treated as a power-on reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      to_q  <= 1'b0;
      pdf_q <= 1'b0;
    end else begin
      unique case (kind)
        RSI_RK_POR: begin
          to_q  <= 1'b0;
          pdf_q <= 1'b0;
        end
        RSI_RK_UVR: begin
          to_q  <= to_q;
          pdf_q <= pdf_q;
        end
        RSI_RK_WDT_RUN: begin
          to_q  <= 1'b1;
          pdf_q <= pdf_q;
        end
        RSI_RK_WDT_LP: begin
          to_q  <= 1'b1;
          pdf_q <= 1'b1;
        end
        RSI_RK_NONE: begin
          // halt and clear-watchdog steer the flags during normal running
          if (i_halt) begin
            to_q  <= 1'b0;
            pdf_q <= 1'b1;
          end else if (i_clr_wdt) begin
            to_q  <= 1'b0;
            pdf_q <= 1'b0;
          end
        end
        default: begin
          to_q  <= 1'b0;
          pdf_q <= 1'b0;
        end
      endcase
    end
  end

  // other status bits belong to the alu; shown as zero here
  always_comb begin
    status_d = RSI_STATUS_RST;
    status_d[RSI_ST_TO_BIT]  = to_q;
    status_d[RSI_ST_PDF_BIT] = pdf_q;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= RSI_STATUS_RST;
    end else begin
      o_status <= status_d;
    end
  end

  // reset-cause flags register; a new event wins over a same-cycle clear
  logic uvr_q;
  logic swr_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      uvr_q <= 1'b0;
    end else if (kind == RSI_RK_UVR) begin
      uvr_q <= 1'b1;
    end else if (i_rcf_clr_uvr) begin
      uvr_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      swr_q <= 1'b0;
    end else if (kind == RSI_RK_POR) begin
      // software-reset cause is defined as zero after power-on
      swr_q <= 1'b0;
    end else if (i_wdt_sw_reset) begin
      swr_q <= 1'b1;
    end else if (i_rcf_clr_swr) begin
      swr_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reset_cause_flags <= RSI_RCF_RST;
    end else begin
      o_reset_cause_flags <= ({5'h00, uvr_q, 1'b0, swr_q} & RSI_RCF_MASK);
    end
  end

  // pc and stack pointer are reset by every kind of reset
  logic any_rst;
  logic full_rst;
  assign any_rst  = (kind != RSI_RK_NONE);
  // low-power watchdog reset spares everything but pc, sp, the time-out/power-down flags and o_core_reset
  assign full_rst = any_rst && (kind != RSI_RK_WDT_LP);

  // only the reset value lives here; the core's sequencer advances the pc
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pc <= RSI_PC_RST;
    end else begin
      o_pc <= RSI_PC_RST;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sp <= RSI_SP_TOP;
    end else begin
      o_sp <= RSI_SP_TOP;
    end
  end

  // control strobes to the peripherals, held one cycle after the reset kind
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_disable <= 1'b1;
    end else begin
      o_int_disable <= full_rst;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wdt_clear <= 1'b1;
    end else begin
      o_wdt_clear <= full_rst;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timers_off <= 1'b1;
    end else begin
      o_timers_off <= full_rst;
    end
  end

  // low-power watchdog reset leaves the port registers alone
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_load <= 1'b1;
    end else begin
      o_port_load <= full_rst;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_core_reset <= 1'b1;
    end else begin
      o_core_reset <= any_rst;
    end
  end

  // watchdog keeps counting through and after any reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wdt_run <= 1'b1;
    end else begin
      o_wdt_run <= 1'b1;
    end
  end

  // port load values, one flop group per port register kind
  logic [7:0] port_data_q;
  logic [7:0] port_dir_q;
  logic [7:0] port_pu_q;
  logic [7:0] port_wu_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      port_data_q <= RSI_PORT_DATA_RST;
    end else begin
      port_data_q <= RSI_PORT_DATA_RST;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      port_dir_q <= RSI_PORT_DIR_RST;
    end else begin
      port_dir_q <= RSI_PORT_DIR_RST;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      port_pu_q <= RSI_PORT_PU_RST;
    end else begin
      port_pu_q <= RSI_PORT_PU_RST;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      port_wu_q <= RSI_PORT_WU_RST;
    end else begin
      port_wu_q <= RSI_PORT_WU_RST;
    end
  end

  assign o_port_init = '{port_data_q, port_dir_q, port_pu_q, port_wu_q};

  // working and table registers: never touched by a reset (undefined at
  // power-on means any value is fine, so zero is used for determinism)
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_working_register <= RSI_ZERO8;
    end else if (i_working_we && !any_rst) begin
      o_working_register <= i_working_d;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_table_pointer_low <= RSI_ZERO8;
    end else if (i_tbl_low_we && !any_rst) begin
      o_table_pointer_low <= i_tbl_low_d;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_table_latch_high <= RSI_ZERO8;
    end else if (i_tbl_high_we && !any_rst) begin
      o_table_latch_high <= i_tbl_high_d;
    end
  end

endmodule

//--- tb/rsi_checker.sv
`timescale 1ns/100ps
module rsi_checker
  import rsi_pkg::*;
(
  input wire logic        i_ref_clk,            // clock
  input wire logic        i_rst,                // reset
  input wire logic        i_power_on,           // por event
  input wire logic        i_undervoltage_reset, // uvr event
  input wire logic        i_wdt_timeout,        // wdt event
  input wire rsi_mode_t   i_mode,               // power mode
  input wire logic [7:0]  o_status,             // status
  input wire logic [7:0]  o_reset_cause_flags,  // cause
  input wire logic [12:0] o_pc,                 // pc
  input wire logic [2:0]  o_sp,                 // sp
  input wire logic        o_int_disable,        // strobe
  input wire logic        o_wdt_clear,          // strobe
  input wire logic        o_timers_off,         // strobe
  input wire logic        o_port_load,          // strobe
  input wire logic        o_core_reset,         // core reset
  input wire logic        o_wdt_run,            // wdt runs
  input wire rsi_port_t   o_port_init,          // port values
  input wire logic [7:0]  o_working_register    // working reg
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic lp;
  assign lp = (i_mode == RSI_MODE_IDLE) || (i_mode == RSI_MODE_SLEEP);
  sequence full_strobes;
    o_int_disable && o_wdt_clear && o_timers_off && o_port_load;
  endsequence
  sequence wdt_lp;
    $rose(i_wdt_timeout) && lp;
  endsequence
  por_clears_flags_a: assert property ($rose(i_power_on) |-> ##[2:5] o_status[5:4] == 2'b00)
    else $error("flags not cleared by power-on");
  por_strobes_a: assert property ($rose(i_power_on) |-> ##[2:5] full_strobes)
    else $error("power-on init strobes missing");
  wdt_lp_flags_a: assert property (wdt_lp |-> ##[2:5] o_status[5:4] == 2'b11)
    else $error("low-power timeout flags wrong");
  wdt_run_flag_a: assert property ($rose(i_wdt_timeout) && !lp |-> ##[2:5] o_status[5])
    else $error("run timeout flag not set");
  wdt_run_pdf_a: assert property ($rose(i_wdt_timeout) && !lp |-> $stable(o_status[4]) [*6])
    else $error("run timeout altered power-down flag");
  uvr_keeps_flags_a: assert property ($rose(i_undervoltage_reset) && !lp |-> $stable(o_status[5:4]) [*6])
    else $error("undervoltage altered flags");
  uvr_cause_set_a: assert property ($rose(i_undervoltage_reset) && !lp |-> ##[2:5] o_reset_cause_flags[2])
    else $error("undervoltage cause not set");
  uvr_lp_ignored_a: assert property ($rose(i_undervoltage_reset) && lp |-> !o_core_reset [*6])
    else $error("undervoltage acted in low power");
  lp_partial_a: assert property (wdt_lp |-> !o_port_load [*6])
    else $error("low-power timeout reloaded ports");
  keep_data_a: assert property ($rose(i_wdt_timeout) |-> ##1 $stable(o_working_register) [*5])
    else $error("timeout changed working register");
  fixed_values_a: assert property (o_pc == RSI_PC_RST && o_sp == RSI_SP_TOP && o_wdt_run && o_port_init == {RSI_PORT_DATA_RST, RSI_PORT_DIR_RST, RSI_PORT_PU_RST, RSI_PORT_WU_RST})
    else $error("fixed init value wrong");
  status_layout_a: assert property ((o_status & 8'hcf) == 8'h00)
    else $error("status spare bits set");
endmodule

bind rsi_reset_state_init rsi_checker rsi_checker_i (.*);

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rsi_pkg::*;
  logic       i_ref_clk = 0, i_rst = 1, i_power_on = 0, i_undervoltage_reset = 0;
  logic       i_wdt_timeout = 0, i_halt = 0, i_clr_wdt = 0, i_wdt_sw_reset = 0;
  logic       i_rcf_clr_uvr = 0, i_rcf_clr_swr = 0;
  logic       i_working_we = 0, i_tbl_low_we = 0, i_tbl_high_we = 0;
  logic [7:0] i_working_d = 0, i_tbl_low_d = 0, i_tbl_high_d = 0;
  rsi_mode_t  i_mode = RSI_MODE_FAST;
  logic [7:0] o_status, o_reset_cause_flags, o_working_register;
  logic [7:0] o_table_pointer_low, o_table_latch_high;
  logic [12:0] o_pc;
  logic [2:0] o_sp;
  logic       o_int_disable, o_wdt_clear, o_wdt_run, o_timers_off, o_port_load, o_core_reset;
  rsi_port_t  o_port_init;
  int         fail_count = 0, samples_checked = 0;
  logic [1:0] flags = 2'b00, cause = 2'b00, cv = 2'b11;
  logic       fv = 1;
  int         cop[$] = '{0, 4, 3, 3, 4, 1, 4, 2, 6, 5, 7};
  logic [3:0] cmd[$] = '{1, 8, 4, 2, 1, 1, 4, 2, 1, 1, 1};

  rsi_reset_state_init rsi_reset_state_init_i (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ops: 0 halt 1 clr_wdt 2 por 3 uvr 4 wdt 5 sw reset 6 clr uvr cause 7 clr sw cause
  function automatic logic [1:0] flags_after(int op, logic lp, logic [1:0] f);
    case (op)
      0: return 2'b01;
      1, 2: return 2'b00;
      4: return lp ? 2'b11 : {1'b1, f[0]};
      default: return f;
    endcase
  endfunction

  task automatic do_op(input int op, input rsi_mode_t m);
    logic [23:0] wd;
    logic        lp;
    wd = 24'($urandom);
    lp = (m == RSI_MODE_IDLE) || (m == RSI_MODE_SLEEP);
    @(posedge i_ref_clk);
    i_mode <= m;
    {i_working_d, i_tbl_low_d, i_tbl_high_d} <= wd;
    {i_working_we, i_tbl_low_we, i_tbl_high_we} <= 3'b111;
    @(posedge i_ref_clk);
    {i_working_we, i_tbl_low_we, i_tbl_high_we} <= 3'b000;
    {i_rcf_clr_swr, i_rcf_clr_uvr, i_wdt_sw_reset, i_wdt_timeout, i_undervoltage_reset,
     i_power_on, i_clr_wdt, i_halt} <= 8'h01 << op;
    @(posedge i_ref_clk);
    {i_rcf_clr_swr, i_rcf_clr_uvr, i_wdt_sw_reset, i_wdt_timeout, i_undervoltage_reset,
     i_power_on, i_clr_wdt, i_halt} <= 8'h00;
    repeat (7) @(posedge i_ref_clk);
    #1;
    flags = flags_after(op, lp, flags);
    // software reset effect on status is not pinned down, so stop checking until redefined
    if (op == 5) fv = 0;
    if (op < 3) fv = 1;
    if (op == 2) {cv, cause[0]} = 3'b010;
    if (op == 3 && !lp) {cause[1], cv[1]} = 2'b11;
    if (op == 5) {cause[0], cv[0]} = 2'b11;
    if (op == 6) {cause[1], cv[1]} = 2'b01;
    if (op == 7) {cause[0], cv[0]} = 2'b01;
    if (fv) chk(32'(o_status), {24'h0, 2'b00, flags, 4'h0});
    chk(32'({o_reset_cause_flags[2], o_reset_cause_flags[0]} & cv), 32'(cause & cv));
    chk(32'({o_pc, o_sp}), 32'({RSI_PC_RST, RSI_SP_TOP}));
    if (op != 2 && op != 5)
      chk(32'({o_working_register, o_table_pointer_low, o_table_latch_high}), 32'(wd));
  endtask

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'h8396));
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 0;
    foreach (cop[k]) do_op(cop[k], rsi_mode_t'(cmd[k]));
    repeat (80) do_op($urandom % 8, rsi_mode_t'(4'h1 << ($urandom % 4)));
    conclude();
  end
endmodule
